// ---- core/pclb_burst_pick.sv ----
`timescale 1ns/1ps
`include "pclb_regs.svh"

module pclb_burst_pick
    import pclb_pkg::*;
#(
    parameter int unsigned AW = 30
) (
    input  wire logic [AW-1:0] dwAddr,
    input  wire logic [3:0]    effLog,
    output logic      [3:0]    stepLog,
    output logic               aligned4,
    output logic               lineAligned
);

    logic       allZero;  // low address bits all clear so far
    logic [3:0] tz;       // trailing zero dwords, capped

    // largest size the address is aligned to, not above line
    always_comb begin
        allZero = 1'b1;
        tz      = 4'h0;
        stepLog = `PCLB_LOG_STEP;
        for (int i = 0; i < 8; i++) begin
            allZero = allZero & ~dwAddr[i];
            if (allZero) begin
                tz = 4'(i + 1);
                if (tz <= effLog && tz >= `PCLB_LOG_STEP) begin
                    stepLog = tz;
                end
            end
        end
        aligned4    = tz >= `PCLB_LOG_STEP;
        lineAligned = tz >= effLog;
    end

endmodule : pclb_burst_pick

// ---- core/pclb_ctrl.sv ----
`timescale 1ns/1ps
`include "pclb_regs.svh"

module pclb_ctrl
    import pclb_pkg::*;
#(
    parameter int unsigned FIFO_W = 11
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              cfgSel,
    input  wire logic              cfgWrite,
    input  wire logic [7:0]        cfgOffset,
    input  wire logic [7:0]        cfgWrData,
    output logic      [7:0]        cfgRdData_q,
    input  wire logic [7:0]        dmaModeReg,
    input  wire logic [7:0]        chipTestThreeReg,
    input  wire logic [7:0]        chipTestFiveReg,
    input  wire logic [15:0]       pciCommandReg,
    input  wire logic              cacheLineSizeEnable,
    input  wire logic              xferStart,
    input  wire logic              xferWrite,
    input  wire logic              xferMemMove,
    input  wire logic [31:0]       xferAddr,
    input  wire logic [31:0]       xferOtherAddr,
    input  wire logic [23:0]       xferBytes,
    input  wire logic [FIFO_W-1:0] fifoBytes,
    input  wire logic              burstAck,
    input  wire logic              engDone,
    input  wire pclbStop_t         engStop,
    input  wire logic [9:0]        engBytes,
    input  wire logic [9:0]        engSoFar,
    input  wire logic              latExpired,
    output logic                   busReq_q,
    output logic                   burstValid_q,
    output pclbBurst_t             burst_q,
    output logic                   trimValid_q,
    output logic      [9:0]        trimBytes_q,
    output logic                   xferBusy_q,
    output logic                   xferDone_q,
    output logic                   cacheActive_q
);

    ////////////////////////////////////////////////////////////////
    // state and storage

    typedef enum logic [1:0] {
        S_IDLE,
        S_PLAN,
        S_ISSUE,
        S_RUN
    } pclbState_t;

    pclbState_t  state_q;        // sequencer state
    logic [7:0]  cls_q;          // cache line size register
    logic [31:0] addr_q;         // next byte address
    logic [23:0] rem_q;          // bytes still to move
    logic        isWrite_q;      // transfer direction
    logic        misalign_q;     // memory move offsets differ
    logic        trimmed_q;      // latency trim applied

    ////////////////////////////////////////////////////////////////
    // configuration decode

    logic [3:0]  maxLog;         // burst size field as log2 dwords
    logic [3:0]  effLog;         // effective line size, log2 dwords
    logic        clsLegal;       // register holds a legal size
    logic        clsUsable;      // register rounds to 2 or more
    logic        wiEnables;      // all invalidate enables set
    logic [10:0] lineBytes;      // line size in bytes
    logic [31:0] lineMask;       // byte mask inside one line
    logic [10:0] maxBytes;       // burst size field in bytes
    logic [3:0]  stepLog;        // stepping burst size
    logic        aligned4;       // on a 4-dword boundary
    logic        lineAligned;    // on a line boundary
    logic        cacheOn;        // alignment logic in force
    logic        wiOk;           // invalidate burst allowed

    // burst field plus extended bit, capped at the largest size
    always_comb begin
        maxLog = 4'({chipTestFiveReg[`PCLB_EXT_BURST_BIT],
                     dmaModeReg[`PCLB_BSIZE_HI:`PCLB_BSIZE_LO]})
                 + `PCLB_LOG_MIN;
        if (maxLog > `PCLB_LOG_MAX) begin
            maxLog = `PCLB_LOG_MAX;
        end
    end

    pclb_line_size #(
        .CLS_W     (8)
    ) u_line (
        .clsValue  (cls_q),
        .maxLog    (maxLog),
        .effLog    (effLog),
        .clsLegal  (clsLegal),
        .clsUsable (clsUsable)
    );

    // alignment of the current dword address
    pclb_burst_pick #(
        .AW          (30)
    ) u_pick (
        .dwAddr      (addr_q[31:2]),
        .effLog      (effLog),
        .stepLog     (stepLog),
        .aligned4    (aligned4),
        .lineAligned (lineAligned)
    );

    assign wiEnables = chipTestThreeReg[`PCLB_WIE_BIT]
                     & pciCommandReg[`PCLB_CMD_WI_BIT]
                     & cacheLineSizeEnable;

    // line size in bytes, used by cache mode planning
    assign lineBytes = 11'h001 << (effLog + `PCLB_DW_SHIFT);
    assign lineMask  = {21'h00_0000, lineBytes - 11'h001};
    assign maxBytes  = 11'h001 << (maxLog + `PCLB_DW_SHIFT);

    // misaligned memory moves run without cache logic
    assign cacheOn = cacheLineSizeEnable && clsUsable && !misalign_q;

    // every invalidate condition at once
    // byte offset and 4-dword checks keep the command in step
    // with the planned shape: a partial or single dword never
    // goes out as an invalidate burst
    assign wiOk = wiEnables && cacheOn && clsLegal && isWrite_q
               && lineAligned && aligned4 && (addr_q[1:0] == 2'h0)
               && ({21'h00_0000, fifoBytes} >= {21'h0, lineBytes})
               && (rem_q >= {13'h0000, lineBytes});

    ////////////////////////////////////////////////////////////////
    // burst planning, recomputed from the remaining count

    logic [23:0] planBytes;      // bytes of the next burst
    logic [23:0] lines;          // whole lines left to move
    logic [23:0] maxLines;       // lines allowed by burst field
    logic [23:0] firstBytes;     // bytes up to the next dword
    logic [3:0]  firstBe;        // enables of the first dword

    // size picked afresh before every burst
    always_comb begin
        lines      = rem_q >> (effLog + `PCLB_DW_SHIFT);
        maxLines   = 24'h00_0001 << (maxLog - effLog);
        firstBytes = 24'(`PCLB_DW_BYTES - {1'b0, addr_q[1:0]});
        if (firstBytes > rem_q) begin
            firstBytes = rem_q;
        end
        planBytes = firstBytes;
        if (addr_q[1:0] != 2'h0) begin
            // partial leading dword in every mode
            planBytes = firstBytes;
        end else if (!cacheOn) begin
            // only the burst size field limits
            planBytes = {13'h0000, maxBytes};
        end else if (!aligned4) begin
            planBytes = firstBytes;
        end else if (wiOk) begin
            // largest multiple, capped by burst field
            if (lines > maxLines) begin
                lines = maxLines;
            end
            planBytes = lines << (effLog + `PCLB_DW_SHIFT);
        end else if (lineAligned) begin
            planBytes = {13'h0000, lineBytes};
        end else begin
            planBytes = 24'h00_0001 << (stepLog + `PCLB_DW_SHIFT);
        end
        if (planBytes > rem_q) begin
            planBytes = rem_q;
        end
        firstBe = 4'hF << addr_q[1:0];
    end

    ////////////////////////////////////////////////////////////////
    // latency trim: run on to the next line boundary

    logic [31:0] curAddr;        // address of the next data phase
    logic [31:0] nextLine;       // that address rounded up to line
    logic [9:0]  trimCalc;       // burst length ending on the line

    // stop point for a timed out invalidate burst
    always_comb begin
        curAddr  = burst_q.addr + {22'h00_0000, engSoFar};
        nextLine = (curAddr + lineMask) & ~lineMask;
        trimCalc = 10'(nextLine - burst_q.addr);
        if (trimCalc == 10'h000) begin
            trimCalc = lineBytes[9:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // line size register on the config port

    // byte write at its offset, other offsets untouched
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cls_q <= `PCLB_CLS_RESET;
        end else if (cfgSel && cfgWrite
                     && cfgOffset == `PCLB_CLS_OFFSET) begin
            cls_q <= cfgWrData;
        end
    end

    // reads back the register, zero elsewhere
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfgRdData_q <= 8'h00;
        end else if (cfgSel && !cfgWrite) begin
            cfgRdData_q <= (cfgOffset == `PCLB_CLS_OFFSET) ? cls_q
                                                           : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // transfer sequencer

    logic [23:0] remAfter;       // remaining bytes after this burst
    assign remAfter = rem_q - {14'h0000, engBytes};

    // state walk: plan, hand over, run, repeat
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= S_IDLE;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (xferStart && xferBytes != 24'h00_0000) begin
                        state_q <= S_PLAN;
                    end
                end
                S_PLAN: begin
                    state_q <= S_ISSUE;
                end
                S_ISSUE: begin
                    if (burstAck) begin
                        state_q <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (engDone) begin
                        state_q <= (remAfter == 24'h00_0000) ? S_IDLE
                                                             : S_PLAN;
                    end
                end
            endcase
        end
    end

    // address, count and direction of the stream
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            addr_q     <= 32'h0000_0000;
            rem_q      <= 24'h00_0000;
            isWrite_q  <= 1'b0;
            misalign_q <= 1'b0;
        end else if (state_q == S_IDLE && xferStart) begin
            addr_q    <= xferAddr;
            rem_q     <= xferBytes;
            isWrite_q <= xferWrite;
            misalign_q <= xferMemMove
                && ((xferAddr & lineMask) != (xferOtherAddr & lineMask));
        end else if (state_q == S_RUN && engDone) begin
            addr_q <= addr_q + {22'h00_0000, engBytes};
            rem_q  <= remAfter;
        end
    end

    // descriptor latched from the plan, held until taken
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            burstValid_q <= 1'b0;
            burst_q      <= '0;
        end else if (state_q == S_PLAN) begin
            burstValid_q  <= 1'b1;
            burst_q.addr  <= addr_q;
            burst_q.bytes <= planBytes[9:0];
            burst_q.be    <= firstBe;
            burst_q.wi    <= wiOk;
            if (!isWrite_q) begin
                burst_q.cmd <= `PCLB_CMD_MR;
            end else if (wiOk) begin
                burst_q.cmd <= `PCLB_CMD_MWI;
            end else begin
                burst_q.cmd <= `PCLB_CMD_MW;
            end
        end else if (state_q == S_ISSUE && burstAck) begin
            burstValid_q <= 1'b0;
        end
    end

    // trim armed once per invalidate burst
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trimValid_q <= 1'b0;
            trimBytes_q <= 10'h000;
            trimmed_q   <= 1'b0;
        end else if (state_q == S_PLAN) begin
            trimValid_q <= 1'b0;
            trimmed_q   <= 1'b0;
        end else if (state_q == S_RUN && !engDone && latExpired
                     && burst_q.wi && !trimmed_q) begin
            trimValid_q <= 1'b1;
            trimBytes_q <= trimCalc;
            trimmed_q   <= 1'b1;
        end else if (state_q == S_RUN && engDone) begin
            trimValid_q <= 1'b0;
        end
    end

    // bus request: a one cycle gap marks each release
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            busReq_q <= 1'b0;
        end else if (state_q == S_PLAN) begin
            busReq_q <= 1'b1;
        end else if (state_q == S_RUN && engDone) begin
            busReq_q <= (remAfter != 24'h00_0000)
                     && engStop == PCLB_STOP_DONE && !trimmed_q;
        end
    end

    // status flags for the surrounding engine
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            xferBusy_q    <= 1'b0;
            xferDone_q    <= 1'b0;
            cacheActive_q <= 1'b0;
        end else begin
            xferBusy_q    <= state_q != S_IDLE
                          || (xferStart && xferBytes != 24'h00_0000);
            xferDone_q    <= state_q == S_RUN && engDone
                          && remAfter == 24'h00_0000;
            cacheActive_q <= cacheOn;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_wi_enables: assert property (
        $rose(burstValid_q) && burst_q.cmd == `PCLB_CMD_MWI
        |-> $past(wiEnables))
        else $error("invalidate issued without enables");

    chk_wi_legal: assert property (
        $rose(burstValid_q) && burst_q.wi |-> $past(clsLegal))
        else $error("invalidate with illegal line size");

    chk_wi_fifo: assert property (
        $rose(burstValid_q) && burst_q.wi
        |-> $past({21'h0, fifoBytes} >= {21'h0, lineBytes}))
        else $error("invalidate without a full line buffered");

    chk_wi_shape: assert property (
        burstValid_q && burst_q.wi
        |-> (burst_q.addr & lineMask) == 32'h0000_0000
         && ({22'h0, burst_q.bytes} & lineMask) == 32'h0000_0000
         && {1'b0, burst_q.bytes} <= maxBytes)
        else $error("invalidate burst not a line multiple");

    chk_single_step: assert property (
        $rose(burstValid_q) && $past(cacheOn)
        && burst_q.addr[3:0] != 4'h0
        |-> burst_q.bytes <= 10'h004)
        else $error("burst before 4-dword boundary");

    chk_plain_off: assert property (
        $rose(burstValid_q) && !$past(cacheLineSizeEnable)
        |-> burst_q.cmd != `PCLB_CMD_MWI)
        else $error("invalidate with cache mode off");

    chk_retry_rereq: assert property (
        state_q == S_RUN && engDone && engStop == PCLB_STOP_RETRY
        && remAfter != 24'h00_0000
        |=> !busReq_q ##1 busReq_q)
        else $error("retry did not release and re-request");

    chk_disc_rereq: assert property (
        state_q == S_RUN && engDone && engStop == PCLB_STOP_DISC
        && remAfter != 24'h00_0000
        |=> !busReq_q ##1 busReq_q)
        else $error("disconnect did not release and re-request");

    chk_trim_line: assert property (
        trimValid_q
        |-> ((burst_q.addr + {22'h0, trimBytes_q}) & lineMask)
            == 32'h0000_0000)
        else $error("latency trim not on line boundary");

endmodule : pclb_ctrl

// ---- core/pclb_line_size.sv ----
`timescale 1ns/1ps
`include "pclb_regs.svh"

module pclb_line_size
    import pclb_pkg::*;
#(
    parameter int unsigned CLS_W = 8
) (
    input  wire logic [CLS_W-1:0] clsValue,
    input  wire logic [3:0]       maxLog,
    output logic      [3:0]       effLog,
    output logic                  clsLegal,
    output logic                  clsUsable
);

    logic [3:0] floorLog;  // log2 of value rounded down
    logic       isPow2;    // value is zero or an exact power of two

    // msb search rounds down to the nearest binary size
    always_comb begin
        floorLog = 4'h0;
        for (int i = 1; i < CLS_W; i++) begin
            if (clsValue[i]) begin
                floorLog = i[3:0];
            end
        end
        isPow2    = (clsValue & (clsValue - 1'b1)) == '0;
        clsUsable = floorLog >= `PCLB_LOG_MIN;
        clsLegal  = clsUsable && isPow2 && (floorLog <= maxLog);
        // smaller of rounded size and burst size wins
        effLog    = (floorLog < maxLog) ? floorLog : maxLog;
    end

endmodule : pclb_line_size

// ---- shared/pclb_pkg.sv ----
package pclb_pkg;

    // one planned bus burst, handed to the bus engine
    typedef struct packed {
        logic [31:0] addr;   // first byte address
        logic [9:0]  bytes;  // byte count of the burst
        logic [3:0]  cmd;    // bus command code
        logic [3:0]  be;     // byte enables of the first dword
        logic        wi;     // write and invalidate burst
    } pclbBurst_t;

    // how the engine ended the last burst
    typedef enum logic [1:0] {
        PCLB_STOP_DONE,
        PCLB_STOP_RETRY,
        PCLB_STOP_DISC
    } pclbStop_t;

endpackage : pclb_pkg

// ---- shared/pclb_regs.svh ----
`ifndef PCLB_REGS_SVH
`define PCLB_REGS_SVH

// config space offset and reset of the line size register
`define PCLB_CLS_OFFSET    8'h0C
`define PCLB_CLS_RESET     8'h00

// bus command codes on the command lines
`define PCLB_CMD_MR        4'h6
`define PCLB_CMD_MW        4'h7
`define PCLB_CMD_MWI       4'hF

// bit positions of the loose enable bits, the extended burst bit and the burst size field
`define PCLB_WIE_BIT       0
`define PCLB_CMD_WI_BIT    4
`define PCLB_EXT_BURST_BIT 2
`define PCLB_BSIZE_HI      7
`define PCLB_BSIZE_LO      6

// burst sizes as log2 of dwords: 2 up to 128, stepping from 4
`define PCLB_LOG_MIN       4'h1
`define PCLB_LOG_STEP      4'h2
`define PCLB_LOG_MAX       4'h7
`define PCLB_DW_SHIFT      4'h2
`define PCLB_DW_BYTES      3'h4

`endif

// ---- tb/pclb_engine_model.sv ----
`timescale 1ns/1ps
module pclb_engine_model
    import pclb_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       burstValid_q,
    input  wire pclbBurst_t burst_q,
    input  wire logic       trimValid_q,
    input  wire logic [9:0] trimBytes_q,
    output logic            burstAck,
    output logic            engDone,
    output logic            latExpired,
    output pclbStop_t       engStop,
    output logic [9:0]      engBytes,
    output logic [9:0]      engSoFar
);
    pclbStop_t  stopKind;   // one-shot ending, set by the bench
    logic       latFire;    // one-shot latency expiry
    int         runLen;     // data phases before the end
    pclbBurst_t b;          // descriptor in flight
    ////////////////////////////////////////////////////////////
    // takes a descriptor, runs it, ends it as commanded
    initial begin
        {burstAck, engDone, latExpired} = 3'b000;
        engStop = PCLB_STOP_DONE;
        stopKind = PCLB_STOP_DONE;
        {engBytes, engSoFar} = 20'h0_0000;
        latFire = 1'b0;
        runLen = 1;
        forever begin
            @(posedge clk_sys);
            if (burstValid_q === 1'b1) begin
                @(negedge clk_sys) burstAck = 1'b1;
                @(negedge clk_sys) burstAck = 1'b0;
                b = burst_q;
                engSoFar = 10'h008;
                repeat (runLen) @(negedge clk_sys);
                // expiry well before the end, never with done
                if (latFire) begin
                    latExpired = 1'b1;
                    @(negedge clk_sys) latExpired = 1'b0;
                    latFire = 1'b0;
                    repeat (2) @(negedge clk_sys);
                end
                engStop = stopKind;
                engBytes = (stopKind == PCLB_STOP_RETRY) ? 10'h000
                         : (stopKind == PCLB_STOP_DISC) ? 10'h020
                         : trimValid_q ? trimBytes_q : b.bytes;
                stopKind = PCLB_STOP_DONE;
                engDone = 1'b1;
                @(negedge clk_sys) engDone = 1'b0;
                // released counts no longer hold the old value
                engStop = PCLB_STOP_DONE;
                engBytes = ~engBytes;
                engSoFar = ~engSoFar;
            end
        end
    end
endmodule : pclb_engine_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "pclb_regs.svh"
module testbench;
    import pclb_pkg::*;
    logic clk_sys, reset, cfgSel, cfgWrite, cacheLineSizeEnable;
    logic [7:0] cfgOffset, cfgWrData, cfgRdData_q, dmaModeReg;
    logic [7:0] chipTestThreeReg, chipTestFiveReg;
    logic [15:0] pciCommandReg;
    logic xferStart, xferWrite, xferMemMove, burstAck, engDone;
    logic latExpired, busReq_q, burstValid_q, trimValid_q;
    logic xferBusy_q, xferDone_q, cacheActive_q;
    logic [31:0] xferAddr, xferOtherAddr, rnd;
    logic [23:0] xferBytes;
    logic [10:0] fifoBytes;
    logic [9:0] engBytes, engSoFar, trimBytes_q;
    pclbStop_t engStop;
    pclbBurst_t burst_q, mon;
    pclbBurst_t expQ[$];    // descriptors still to be seen
    int mismatches, tests_run;

    pclb_ctrl dut_u (.*);
    pclb_engine_model eng_u (.*);

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic chk(input string w, input logic [31:0] e, s);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask : chk

    task automatic stop_test();
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic cfg(input logic wr, input logic [7:0] off, d);
        @(negedge clk_sys);
        cfgSel = 1'b1;
        cfgWrite = wr;
        cfgOffset = off;
        cfgWrData = d;
        @(negedge clk_sys) cfgSel = 1'b0;
    endtask : cfg

    task automatic rd(input string w, input logic [7:0] off, e);
        cfg(1'b0, off, 8'h00);
        @(negedge clk_sys);
        chk(w, 32'(e), 32'(cfgRdData_q));
    endtask : rd

    task automatic exp(input logic [31:0] a, input logic [9:0] n,
                       input logic [3:0] c);
        pclbBurst_t e;
        e = '0;
        e.addr = a;
        e.bytes = n;
        e.cmd = c;
        e.be = 4'hF << a[1:0];
        e.wi = (c == `PCLB_CMD_MWI);
        expQ.push_back(e);
    endtask : exp

    // one stream, then a bounded wait for its end
    task automatic xfer(input string w, input logic wr, mm,
                        input logic [31:0] a, input logic [23:0] n);
        int k;
        rnd = xs(rnd);
        eng_u.runLen = 1 + int'(rnd[1:0]);
        @(negedge clk_sys);
        xferStart = 1'b1;
        xferWrite = wr;
        xferMemMove = mm;
        xferAddr = a;
        xferOtherAddr = mm ? 32'h0000_0024 : rnd;
        xferBytes = n;
        @(negedge clk_sys) xferStart = 1'b0;
        chk({w, " busy"}, 1, 32'(xferBusy_q));
        k = 0;
        while (xferDone_q !== 1'b1 && k < 2000) begin
            @(negedge clk_sys);
            k++;
        end
        chk({w, " done"}, 1, 32'(xferDone_q));
        chk({w, " req"}, 0, 32'(busReq_q));
        chk({w, " left"}, 0, expQ.size());
        expQ.delete();
        $display("test %s finished", w);
    endtask : xfer
    ////////////////////////////////////////////////////////////
    // each accepted descriptor against the oldest note
    always @(posedge clk_sys) begin
        if (burstValid_q === 1'b1 && burstAck === 1'b1) begin
            if (expQ.size() == 0) chk("extra burst", 0, 1);
            else begin
                mon = expQ.pop_front();
                chk("addr", mon.addr, burst_q.addr);
                chk("bytes", 32'(mon.bytes), 32'(burst_q.bytes));
                chk("cmd", 32'(mon.cmd), 32'(burst_q.cmd));
                chk("be", 32'(mon.be), 32'(burst_q.be));
                chk("wi", 32'(mon.wi), 32'(burst_q.wi));
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        {reset, cfgSel, cfgWrite, xferStart, xferWrite} = 5'h1_F & 5'h10;
        {xferMemMove, cacheLineSizeEnable} = 2'b00;
        {cfgOffset, cfgWrData, dmaModeReg} = 24'h00_0000;
        {chipTestThreeReg, chipTestFiveReg} = 16'h0000;
        pciCommandReg = 16'h0000;
        {xferAddr, xferOtherAddr, xferBytes} = 88'h0;
        fifoBytes = 11'h7FF;
        rnd = 32'h0000_0031;
        {mismatches, tests_run} = 64'h0;
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        rd("cls reset", 8'h0C, 8'h00);
        cfg(1'b1, 8'h0C, 8'h10);
        rd("cls", 8'h0C, 8'h10);
        rnd = xs(rnd);
        cfg(1'b1, 8'h10, rnd[7:0]);
        rd("unmapped", 8'h10, 8'h00);
        $display("test config finished");
        cacheLineSizeEnable = 1'b1;
        dmaModeReg = 8'hC0;
        chipTestThreeReg = 8'h01;
        pciCommandReg = 16'h0010;
        exp(32'h01, 10'd3, `PCLB_CMD_MR);
        exp(32'h04, 10'd4, `PCLB_CMD_MR);
        exp(32'h08, 10'd4, `PCLB_CMD_MR);
        exp(32'h0C, 10'd4, `PCLB_CMD_MR);
        exp(32'h10, 10'd16, `PCLB_CMD_MR);
        exp(32'h20, 10'd32, `PCLB_CMD_MR);
        exp(32'h40, 10'd64, `PCLB_CMD_MR);
        xfer("align", 1'b0, 1'b0, 32'h01, 24'd127);
        chk("cache on", 1, 32'(cacheActive_q));
        cacheLineSizeEnable = 1'b0;
        dmaModeReg = 8'h00;
        exp(32'h01, 10'd3, `PCLB_CMD_MW);
        exp(32'h04, 10'd8, `PCLB_CMD_MW);
        exp(32'h0C, 10'd8, `PCLB_CMD_MW);
        xfer("nocache", 1'b1, 1'b0, 32'h01, 24'd19);
        cacheLineSizeEnable = 1'b1;
        dmaModeReg = 8'hC0;
        exp(32'h10, 10'd64, `PCLB_CMD_MR);
        xfer("memmove", 1'b0, 1'b1, 32'h10, 24'd64);
        chk("cache off", 0, 32'(cacheActive_q));
        chipTestFiveReg = 8'h04;
        exp(32'h100, 10'd192, `PCLB_CMD_MWI);
        xfer("invalidate", 1'b1, 1'b0, 32'h100, 24'd192);
        fifoBytes = 11'h020;
        exp(32'h100, 10'd64, `PCLB_CMD_MW);
        xfer("fifo short", 1'b1, 1'b0, 32'h100, 24'd64);
        fifoBytes = 11'h7FF;
        cfg(1'b1, 8'h0C, 8'h18);
        exp(32'h100, 10'd64, `PCLB_CMD_MW);
        xfer("cls illegal", 1'b1, 1'b0, 32'h100, 24'd64);
        chipTestFiveReg = 8'h00;
        cfg(1'b1, 8'h0C, 8'h20);
        exp(32'h100, 10'd64, `PCLB_CMD_MW);
        xfer("cls over", 1'b1, 1'b0, 32'h100, 24'd64);
        chipTestFiveReg = 8'h04;
        cfg(1'b1, 8'h0C, 8'h10);
        eng_u.stopKind = PCLB_STOP_RETRY;
        exp(32'h100, 10'd192, `PCLB_CMD_MWI);
        exp(32'h100, 10'd192, `PCLB_CMD_MWI);
        xfer("retry", 1'b1, 1'b0, 32'h100, 24'd192);
        eng_u.stopKind = PCLB_STOP_DISC;
        exp(32'h100, 10'd192, `PCLB_CMD_MWI);
        exp(32'h120, 10'd32, `PCLB_CMD_MW);
        exp(32'h140, 10'd128, `PCLB_CMD_MWI);
        xfer("disconnect", 1'b1, 1'b0, 32'h100, 24'd192);
        eng_u.latFire = 1'b1;
        exp(32'h100, 10'd192, `PCLB_CMD_MWI);
        exp(32'h140, 10'd128, `PCLB_CMD_MWI);
        xfer("latency", 1'b1, 1'b0, 32'h100, 24'd192);
        stop_test();
    end
endmodule : testbench
